// ==== src/tmr16_pkg.sv ====
// Register map, field positions and shared types of the 16-bit timer
package tmr16_pkg;

  localparam logic [11:0] ADDR_CTRL_A = 12'h000;
  localparam logic [11:0] ADDR_CTRL_B = 12'h004;
  localparam logic [11:0] ADDR_CTRL_C = 12'h008;
  localparam logic [11:0] ADDR_CNT_L = 12'h00C;
  localparam logic [11:0] ADDR_CNT_H = 12'h010;
  localparam logic [11:0] ADDR_CMPA_L = 12'h014;
  localparam logic [11:0] ADDR_CMPA_H = 12'h018;
  localparam logic [11:0] ADDR_CMPB_L = 12'h01C;
  localparam logic [11:0] ADDR_CMPB_H = 12'h020;
  localparam logic [11:0] ADDR_CAP_L = 12'h024;
  localparam logic [11:0] ADDR_CAP_H = 12'h028;
  localparam logic [11:0] ADDR_MASK = 12'h02C;
  localparam logic [11:0] ADDR_FLAGS = 12'h030;
  localparam logic [11:0] ADDR_GLOBAL = 12'h034;
  localparam logic [11:0] ADDR_ACK = 12'h038;

  localparam int B_FILT = 7;
  localparam int B_EDGE = 6;
  localparam int B_ACOMP = 7;
  localparam int B_FOCA = 7;
  localparam int B_FOCB = 6;
  localparam int B_CAP = 5;
  localparam int B_CMPB = 2;
  localparam int B_CMPA = 1;
  localparam int B_OVF = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] IRQ_BITS = 8'h27;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hFFFF;
  localparam logic [3:0] FILT_SAMPLES = 4'h4;

  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_64 = 10'h03F;
  localparam logic [9:0] DIV_256 = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;

  typedef struct packed {
    logic cap;
    logic cmpb;
    logic cmpa;
    logic ovf;
  } tmr16_evt_s;

endpackage

// ==== src/tmr16_timer.sv ====
// 16-bit timer/counter with capture, two compare units and APB registers
`timescale 1ns/10ps

//==================================================================
// Contract
// - Filter needs four equal successive samples before its output changes.
// - Edge select zero captures on falling edge, one on rising edge.
// - Capture copies counter into capture value and sets capture flag.
// - Capture as TOP disconnects pin and disables input capture.
// - Clock select maps stop, /1, /8, /64, /256, /1024, ext fall, rise.
// - External pin edges count even if the pin is an output.
// - Force strobes act only in non-PWM waveform modes.
// - Force strobe applies compare output mode to output immediately.
// - Force sets no flag, raises no interrupt, never clears counter.
// - Force strobe bits always read as zero.
// - One shared high-byte latch makes 16-bit accesses atomic.
// - Counter write blocks compare match on the next timer clock.
// - Compare registers compared continuously; match drives flag and pin.
// - Capture source selectable as analog comparator output.
// - Interrupt requested only when enable, global flag and flag set.
// - With capture value as TOP, capture flag sets at TOP.
// - Flags clear by vector acknowledge or by writing one.
// - Compare flags set in timer clock after the match.
// - Overflow flag sets at MAX, TOP or BOTTOM per waveform mode.
module tmr16_timer
  import tmr16_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin,
  input wire logic analog_comp_out,
  input wire logic external_count_pin,
  output logic compare_output_pin_a,
  output logic compare_output_pin_b,
  output logic compare_oe_a,
  output logic compare_oe_b,
  output logic irq_capture,
  output logic irq_compare_a,
  output logic irq_compare_b,
  output logic irq_overflow
);

  //==================================================================
  // Registers
  logic [7:0] ctrl_a_r, ctrl_b_r, mask_r, hi_latch_r;
  logic [15:0] cnt_r, cmpa_r, cmpb_r, cap_r;
  logic [15:0] cmpa_buf_r, cmpb_buf_r;
  logic acomp_sel_r, gie_r;
  tmr16_evt_s flags_r;
  logic up_r, block_r;
  logic [9:0] pre_r;
  logic ext_d_r, cap_d_r, filt_out_r;
  logic [3:0] filt_cnt_r;
  logic oca_r, ocb_r;

  //==================================================================
  // Decode
  wire wr = psel && penable && pready && pwrite;
  wire [3:0] wgm = {ctrl_b_r[4:3], ctrl_a_r[1:0]};
  wire [2:0] cs = ctrl_b_r[2:0];
  wire [1:0] com_a = ctrl_a_r[7:6];
  wire [1:0] com_b = ctrl_a_r[5:4];

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] m,
      input logic [15:0] a, input logic [15:0] icr);
    case (m)
      4'h1, 4'h5: top_of = 16'h00FF;
      4'h2, 4'h6: top_of = 16'h01FF;
      4'h3, 4'h7: top_of = 16'h03FF;
      4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
      4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
      default: top_of = MAX_VAL;
    endcase
  endfunction

  function automatic logic oc_next(input logic [1:0] com, input logic cur);
    case (com)
      2'h1: oc_next = !cur;
      2'h2: oc_next = 1'b0;
      2'h3: oc_next = 1'b1;
      default: oc_next = cur;
    endcase
  endfunction

  wire icr_top = (wgm == 4'h8 || wgm == 4'hA || wgm == 4'hC ||
                  wgm == 4'hE);
  wire pwm = is_pwm(wgm);
  wire dual = (wgm >= 4'h1 && wgm <= 4'h3) || (wgm >= 4'h8 && wgm <= 4'hB);
  wire fast = (wgm >= 4'h5 && wgm <= 4'h7) || wgm == 4'hE || wgm == 4'hF;
  wire clear_on_match_mode = (wgm == 4'h4 || wgm == 4'hC);
  wire [15:0] top = top_of(wgm, cmpa_r, cap_r);

  // Clock select and prescaler taps
  wire ext_rise = external_count_pin && !ext_d_r;
  wire ext_fall = !external_count_pin && ext_d_r;
  logic tick;
  always_comb
  begin
    case (cs)
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_r[2:0] == DIV_8[2:0]);
      3'h3: tick = (pre_r[5:0] == DIV_64[5:0]);
      3'h4: tick = (pre_r[7:0] == DIV_256[7:0]);
      3'h5: tick = (pre_r == DIV_1024);
      3'h6: tick = ext_fall;
      3'h7: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // Capture source, filter and edge
  wire cap_src = acomp_sel_r ? analog_comp_out : capture_input_pin;
  wire cap_in = ctrl_b_r[B_FILT] ? filt_out_r : cap_src;
  wire cap_edge = ctrl_b_r[B_EDGE] ? (cap_in && !cap_d_r)
                                   : (!cap_in && cap_d_r);
  wire cap_evt = cap_edge && !icr_top;

  // Counter sequencing
  wire at_top = (cnt_r == top);
  wire at_bot = (cnt_r == RST_WORD);
  wire wr_cnt_l = wr && paddr == ADDR_CNT_L;
  wire match_a = (cnt_r == cmpa_r) && !block_r;
  wire match_b = (cnt_r == cmpb_r) && !block_r;
  wire going_up = dual ? (up_r ? !at_top : at_bot) : 1'b1;
  logic [15:0] cnt_step;
  always_comb
  begin
    if (!dual && (at_top || (clear_on_match_mode && at_top)) && wgm != 4'h0)
      cnt_step = RST_WORD;
    else if (going_up)
      cnt_step = cnt_r + 16'h0001;
    else
      cnt_step = cnt_r - 16'h0001;
  end

  // Overflow point per waveform mode
  wire ovf_evt = tick && (pwm ? (fast ? at_top : at_bot && !up_r)
                              : cnt_r == MAX_VAL);
  wire captop_evt = tick && icr_top && at_top;

  wire [7:0] wbyte = pwdata[7:0];
  wire wr_flags = wr && paddr == ADDR_FLAGS;
  wire wr_ack = wr && paddr == ADDR_ACK;
  wire [3:0] clr = (wr_flags ? {wbyte[B_CAP], wbyte[B_CMPB], wbyte[B_CMPA],
                                wbyte[B_OVF]} : 4'h0)
                 | (wr_ack ? {wbyte[B_CAP], wbyte[B_CMPB], wbyte[B_CMPA],
                              wbyte[B_OVF]} : 4'h0);
  wire [3:0] setf = {cap_evt || captop_evt, tick && match_b,
                     tick && match_a, ovf_evt};
  wire [3:0] flags_nxt = setf | (flags_r & ~clr);
  wire force_ok = wr && paddr == ADDR_CTRL_C && !pwm;

  logic [7:0] rdata;
  always_comb
  begin
    case (paddr)
      ADDR_CTRL_A: rdata = ctrl_a_r;
      ADDR_CTRL_B: rdata = ctrl_b_r;
      ADDR_CTRL_C: rdata = RST_BYTE;
      ADDR_CNT_L: rdata = cnt_r[7:0];
      ADDR_CNT_H: rdata = hi_latch_r;
      ADDR_CMPA_L: rdata = cmpa_buf_r[7:0];
      ADDR_CMPA_H: rdata = hi_latch_r;
      ADDR_CMPB_L: rdata = cmpb_buf_r[7:0];
      ADDR_CMPB_H: rdata = hi_latch_r;
      ADDR_CAP_L: rdata = cap_r[7:0];
      ADDR_CAP_H: rdata = hi_latch_r;
      ADDR_MASK: rdata = mask_r & IRQ_BITS;
      ADDR_FLAGS: rdata = {2'h0, flags_r.cap, 2'h0, flags_r.cmpb,
                           flags_r.cmpa, flags_r.ovf};
      ADDR_GLOBAL: rdata = {acomp_sel_r, 6'h00, gie_r};
      default: rdata = RST_BYTE;
    endcase
  end
  wire bad_addr = paddr > ADDR_ACK || paddr[1:0] != 2'h0;

  //==================================================================
  // Bus slave
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && bad_addr;
      prdata <= {24'h00_0000, rdata};
    end
  end

  //==================================================================
  // Control and 16-bit register access
  wire acc = psel && penable && pready;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_a_r <= RST_BYTE;
      ctrl_b_r <= RST_BYTE;
      mask_r <= RST_BYTE;
      gie_r <= 1'b0;
      acomp_sel_r <= 1'b0;
      hi_latch_r <= RST_BYTE;
      cmpa_buf_r <= RST_WORD;
      cmpb_buf_r <= RST_WORD;
    end
    else if (acc && pwrite)
    begin
      case (paddr)
        ADDR_CTRL_A: ctrl_a_r <= wbyte;
        ADDR_CTRL_B: ctrl_b_r <= wbyte & CTRL_B_MASK;
        ADDR_MASK: mask_r <= wbyte & IRQ_BITS;
        ADDR_GLOBAL:
        begin
          gie_r <= wbyte[0];
          acomp_sel_r <= wbyte[B_ACOMP];
        end
        ADDR_CNT_H, ADDR_CMPA_H, ADDR_CMPB_H, ADDR_CAP_H:
          hi_latch_r <= wbyte;
        ADDR_CMPA_L: cmpa_buf_r <= {hi_latch_r, wbyte};
        ADDR_CMPB_L: cmpb_buf_r <= {hi_latch_r, wbyte};
        default: hi_latch_r <= hi_latch_r;
      endcase
    end
    else if (acc && !pwrite)
    begin
      case (paddr)
        ADDR_CNT_L: hi_latch_r <= cnt_r[15:8];
        ADDR_CAP_L: hi_latch_r <= cap_r[15:8];
        ADDR_CMPA_L: hi_latch_r <= cmpa_buf_r[15:8];
        ADDR_CMPB_L: hi_latch_r <= cmpb_buf_r[15:8];
        default: hi_latch_r <= hi_latch_r;
      endcase
    end
  end

  //==================================================================
  // Counter, compare, capture
  wire upd_cmp = !pwm ||
                 (tick && ((fast || wgm[3:1] == 3'h4) ? at_bot : at_top));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= RST_WORD;
      cmpa_r <= RST_WORD;
      cmpb_r <= RST_WORD;
      cap_r <= RST_WORD;
      up_r <= 1'b1;
      block_r <= 1'b0;
      pre_r <= 10'h000;
      ext_d_r <= 1'b0;
      cap_d_r <= 1'b0;
      flags_r <= '0;
    end
    else
    begin
      pre_r <= (cs == 3'h0) ? 10'h000 : pre_r + 10'h001;
      ext_d_r <= external_count_pin;
      cap_d_r <= cap_in;
      flags_r <= flags_nxt; // set wins over clear
      if (upd_cmp)
      begin
        cmpa_r <= cmpa_buf_r;
        cmpb_r <= cmpb_buf_r;
      end
      if (acc && pwrite && paddr == ADDR_CNT_L)
      begin
        cnt_r <= {hi_latch_r, wbyte};
        block_r <= 1'b1;
      end
      else if (tick)
      begin
        cnt_r <= cnt_step;
        block_r <= 1'b0;
        if (dual)
          up_r <= going_up;
      end
      if (acc && pwrite && paddr == ADDR_CAP_L)
        cap_r <= {hi_latch_r, wbyte};
      else if (cap_evt)
        cap_r <= cnt_r;
    end
  end

  // Noise filter: four equal samples before output follows
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      filt_cnt_r <= 4'h0;
      filt_out_r <= 1'b0;
    end
    else if (cap_src == filt_out_r)
      filt_cnt_r <= 4'h0;
    else if (filt_cnt_r == FILT_SAMPLES - 4'h1)
    begin
      filt_out_r <= cap_src;
      filt_cnt_r <= 4'h0;
    end
    else
      filt_cnt_r <= filt_cnt_r + 4'h1;
  end

  //==================================================================
  // Waveform outputs and interrupt requests
  wire fa = force_ok && wbyte[B_FOCA] && acc;
  wire fb = force_ok && wbyte[B_FOCB] && acc;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      oca_r <= 1'b0;
      ocb_r <= 1'b0;
      compare_oe_a <= 1'b0;
      compare_oe_b <= 1'b0;
      irq_capture <= 1'b0;
      irq_compare_a <= 1'b0;
      irq_compare_b <= 1'b0;
      irq_overflow <= 1'b0;
    end
    else
    begin
      compare_oe_a <= com_a != 2'h0;
      compare_oe_b <= com_b != 2'h0;
      if (fa || (tick && match_a))
        oca_r <= oc_next(com_a, oca_r);
      if (fb || (tick && match_b))
        ocb_r <= oc_next(com_b, ocb_r);
      irq_capture <= gie_r && mask_r[B_CAP] && flags_nxt[3];
      irq_compare_b <= gie_r && mask_r[B_CMPB] && flags_nxt[2];
      irq_compare_a <= gie_r && mask_r[B_CMPA] && flags_nxt[1];
      irq_overflow <= gie_r && mask_r[B_OVF] && flags_nxt[0];
    end
  end
  assign compare_output_pin_a = oca_r;
  assign compare_output_pin_b = ocb_r;

  //==================================================================
  // Checks
  chk_capture_copy: assert property (@(posedge clk)
    disable iff (!rst_n)
    cap_evt && !(acc && pwrite && paddr == ADDR_CAP_L)
    |=> cap_r == $past(cnt_r) && flags_r.cap)
    else $error("capture did not copy counter");
  chk_force_read: assert property (@(posedge clk)
    disable iff (!rst_n)
    pready && !pwrite && paddr == ADDR_CTRL_C |-> prdata == 32'h0000_0000)
    else $error("force bits read nonzero");
  chk_irq_gate: assert property (@(posedge clk)
    disable iff (!rst_n)
    irq_overflow |-> $past(gie_r) && $past(mask_r[B_OVF]))
    else $error("overflow irq without enable");
  chk_cnt_block: assert property (@(posedge clk)
    disable iff (!rst_n)
    acc && pwrite && paddr == ADDR_CNT_L |=> !match_a && !match_b)
    else $error("match after counter write");
  chk_cmp_flag: assert property (@(posedge clk)
    disable iff (!rst_n)
    tick && match_a |=> flags_r.cmpa)
    else $error("compare flag A not set");
  chk_flag_clear: assert property (@(posedge clk)
    disable iff (!rst_n)
    wr_flags && wbyte[B_OVF] && !ovf_evt |=> !flags_r.ovf)
    else $error("overflow flag not cleared");
  chk_cap_disc: assert property (@(posedge clk)
    disable iff (!rst_n)
    icr_top && !(acc && pwrite && paddr == ADDR_CAP_L) |=> $stable(cap_r))
    else $error("capture active while capture is TOP");
  chk_ctrlb_rsv: assert property (@(posedge clk)
    disable iff (!rst_n)
    !ctrl_b_r[5])
    else $error("reserved bit stored");
  chk_stop_hold: assert property (@(posedge clk)
    disable iff (!rst_n)
    cs == 3'h0 && !wr_cnt_l |=> $stable(cnt_r))
    else $error("counter moved while stopped");

endmodule

// ==== test/tb_top.sv ====
// Bench: APB master, pin partner and scenarios for the 16-bit timer
`timescale 1ns/10ps
module tb_top
  import tmr16_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, cap_pin, acomp, ext_pin;
  logic pin_a, pin_b, oe_a, oe_b, irq_c, irq_a, irq_b, irq_o, p;
  logic [15:0] q, w, err;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  tmr16_timer dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
    .analog_comp_out(acomp), .external_count_pin(ext_pin),
    .compare_output_pin_a(pin_a), .compare_output_pin_b(pin_b),
    .compare_oe_a(oe_a), .compare_oe_b(oe_b), .irq_capture(irq_c),
    .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq_overflow(irq_o)
  );
  tmr16_pins_model pins_u (
    .clk(clk), .capture_input_pin(cap_pin), .analog_comp_out(acomp),
    .external_count_pin(ext_pin)
  );

  //==============================================================
  // Bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = {8'h00, prdata[7:0]};
    err = {15'h0000, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // High byte first through the shared latch, low byte commits
  task automatic wr16(input logic [11:0] a, input logic [15:0] v);
    wr(a + 12'h004, v[15:8]);
    wr(a, v[7:0]);
  endtask
  task automatic rd16(input logic [11:0] a);
    rd(a);
    w[7:0] = q[7:0];
    rd(a + 12'h004);
    w[15:8] = q[7:0];
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic arm(input logic [7:0] cb, input logic [15:0] cnt);
    wr(ADDR_CTRL_B, cb);
    wr16(ADDR_CNT_L, cnt);
    wr(ADDR_FLAGS, 8'h27);
  endtask
  task automatic look(input logic [15:0] cap, input logic [15:0] f);
    ticks(12);
    rd16(ADDR_CAP_L);
    chk(w, cap);
    rd(ADDR_FLAGS);
    chk(q & 16'h0020, f);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  //==============================================================
  // Scenarios
  task automatic t_reset();
    logic [11:0] regs [5];
    regs = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_MASK, ADDR_FLAGS};
    foreach (regs[i])
    begin
      rd(regs[i]);
      chk(q, {8'h00, RST_BYTE});
    end
    rd(12'h03C);
    chk(err | q, 16'h0001);
    wr(ADDR_CTRL_B, 8'h20);
    rd(ADDR_CTRL_B);
    chk(q, 16'h0000);
  endtask
  task automatic t_prescale();
    int divs [5];
    divs = '{1, 8, 64, 256, 1024};
    foreach (divs[i])
    begin
      wr(ADDR_CTRL_B, 8'h00);
      wr16(ADDR_CNT_L, 16'h0000);
      wr(ADDR_CTRL_B, 8'(i + 1));
      ticks(16 * divs[i] - 3);
      wr(ADDR_CTRL_B, 8'h00);
      rd(ADDR_CNT_L);
      chk((q >= 16'h000F && q <= 16'h0011) ? 16'h0010 : q, 16'h0010);
    end
    w = q;
    ticks(40);
    rd(ADDR_CNT_L);
    chk(q, w);
  endtask
  task automatic t_ext();
    wr(ADDR_CTRL_B, 8'h07);
    wr16(ADDR_CNT_L, 16'h0000);
    pins_u.ext_pulses(5);
    ticks(5);
    rd(ADDR_CNT_L);
    chk(q, 16'h0005);
    wr(ADDR_CTRL_B, 8'h06);
    pins_u.ext_pulses(3);
    ticks(5);
    rd(ADDR_CNT_L);
    chk(q, 16'h0008);
    wr(ADDR_CTRL_B, 8'h00);
  endtask
  task automatic t_capture();
    arm(8'h40, 16'h0155);
    pins_u.cap_to(1'b1);
    look(16'h0155, 16'h0020);
    arm(8'h00, 16'h0266);
    pins_u.cap_to(1'b0);
    look(16'h0266, 16'h0020);
    arm(8'hC0, 16'h0377);
    pins_u.cap_glitch();
    look(16'h0266, 16'h0000);
    pins_u.cap_to(1'b1);
    look(16'h0377, 16'h0020);
    wr(ADDR_GLOBAL, 8'h80);
    arm(8'h40, 16'h0488);
    pins_u.comp_to(1'b1);
    look(16'h0488, 16'h0020);
    // Disable capture before the source returns to the pin
    wr(ADDR_CTRL_B, 8'h18);
    wr(ADDR_GLOBAL, 8'h00);
    wr16(ADDR_CAP_L, 16'h0700);
    arm(8'h18, 16'h0599);
    pins_u.cap_to(1'b0);
    pins_u.cap_to(1'b1);
    look(16'h0700, 16'h0000);
    arm(8'h19, 16'h06F0);
    ticks(30);
    look(16'h0700, 16'h0020);
    wr(ADDR_CTRL_B, 8'h18);
  endtask
  task automatic t_irq();
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_MASK, 8'h20);
    ticks(2);
    chk({15'h0000, irq_c}, 16'h0000);
    wr(ADDR_GLOBAL, 8'h01);
    ticks(2);
    chk({15'h0000, irq_c}, 16'h0001);
    wr(ADDR_ACK, 8'h20);
    ticks(2);
    chk({15'h0000, irq_c}, 16'h0000);
    rd(ADDR_FLAGS);
    chk(q, 16'h0000);
    wr(ADDR_GLOBAL, 8'h00);
  endtask
  task automatic t_force();
    wr(ADDR_CTRL_B, 8'h08);
    wr16(ADDR_CNT_L, 16'h0033);
    wr16(ADDR_CMPA_L, 16'h0100);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_FLAGS, 8'h27);
    chk({14'h0000, oe_a, oe_b}, 16'h0002);
    p = pin_a;
    wr(ADDR_CTRL_C, 8'h80);
    ticks(2);
    chk({15'h0000, pin_a}, {15'h0000, ~p});
    rd(ADDR_CTRL_C);
    chk(q, 16'h0000);
    rd(ADDR_FLAGS);
    chk(q, 16'h0000);
    rd(ADDR_CNT_L);
    chk(q, 16'h0033);
    wr(ADDR_CTRL_A, 8'hF0);
    wr(ADDR_CTRL_C, 8'hC0);
    ticks(2);
    chk({14'h0000, pin_a, pin_b}, 16'h0003);
    wr(ADDR_CTRL_A, 8'hA1);
    wr(ADDR_CTRL_C, 8'hC0);
    ticks(2);
    chk({14'h0000, pin_a, pin_b}, 16'h0003);
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
  endtask
  task automatic t_block();
    wr16(ADDR_CMPA_L, 16'h0005);
    wr16(ADDR_CMPB_L, 16'h8000);
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_FLAGS, 8'h27);
    wr16(ADDR_CNT_L, 16'h0005);
    ticks(20);
    rd(ADDR_FLAGS);
    chk(q & 16'h0002, 16'h0000);
  endtask
  task automatic t_match();
    wr(ADDR_CTRL_B, 8'h00);
    wr16(ADDR_CNT_L, 16'h0000);
    wr16(ADDR_CMPA_L, 16'h0020);
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_FLAGS, 8'h27);
    p = pin_a;
    wr(ADDR_CTRL_B, 8'h01);
    ticks(60);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS);
    chk(q & 16'h0003, 16'h0002);
    chk({15'h0000, pin_a}, {15'h0000, ~p});
    wr(ADDR_MASK, 8'h06);
    wr(ADDR_GLOBAL, 8'h01);
    ticks(2);
    chk({12'h000, irq_c, irq_a, irq_b, irq_o}, 16'h0004);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS);
    chk(q & 16'h0003, 16'h0000);
    wr16(ADDR_CNT_L, 16'hFFF0);
    wr(ADDR_CTRL_B, 8'h01);
    ticks(30);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_FLAGS);
    chk(q & 16'h0001, 16'h0001);
    wr(ADDR_MASK, 8'h01);
    ticks(2);
    chk({13'h0000, irq_a, irq_b, irq_o}, 16'h0001);
    wr(ADDR_GLOBAL, 8'h00);
    wr(ADDR_CNT_H, 8'hAB);
    wr(ADDR_CMPB_L, 8'h56);
    rd16(ADDR_CMPB_L);
    chk(w, 16'hAB56);
  endtask

  //==============================================================
  // Run control
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_prescale();
    t_ext();
    t_capture();
    t_irq();
    t_force();
    t_block();
    t_match();
    finish_test();
  end
endmodule

// ==== test/tmr16_pins_model.sv ====
// Pin-side model: capture input, comparator output and count clock
`timescale 1ns/10ps
module tmr16_pins_model (
  input wire logic clk,
  output logic capture_input_pin,
  output logic analog_comp_out,
  output logic external_count_pin
);
  initial
  begin
    capture_input_pin = 1'b0;
    analog_comp_out = 1'b0;
    external_count_pin = 1'b0;
  end
  task automatic cap_to(input logic v);
    @(posedge clk) capture_input_pin <= v;
  endtask
  // Pulse shorter than the filter window
  task automatic cap_glitch();
    @(posedge clk) capture_input_pin <= 1'b1;
    repeat (2) @(posedge clk);
    capture_input_pin <= 1'b0;
  endtask
  task automatic comp_to(input logic v);
    @(posedge clk) analog_comp_out <= v;
  endtask
  // Count clock stands low between bursts
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk) external_count_pin <= 1'b1;
      repeat (3) @(posedge clk);
      external_count_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
